// ==== design/eb_embedded_block_ram.sv ====
// Embedded block memory: RAM, ROM or FIFO with preload and APB configuration
//
// Decided for this implementation: register access over APB and the address map.
module eb_embedded_block_ram #(
  parameter bit         INIT_FROM_FLASH = 1'b0,
  parameter logic [15:0] INIT_BASE      = 16'h0000,
  parameter logic [2:0]  CS_MATCH_A     = 3'h7,
  parameter logic [2:0]  CS_MATCH_B     = 3'h7
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        ce_a,
  input  wire logic        output_register_gate_a,
  input  wire logic        port_rst_a,
  input  wire logic [1:0]  byte_lane_enable_a,
  input  wire logic        we_a,
  input  wire logic [2:0]  cs_a,
  input  wire logic [12:0] addr_a,
  input  wire logic [17:0] din_a,
  output logic      [17:0] dout_a,
  input  wire logic        ce_b,
  input  wire logic        output_register_gate_b,
  input  wire logic        port_rst_b,
  input  wire logic [1:0]  byte_lane_enable_b,
  input  wire logic        we_b,
  input  wire logic [2:0]  cs_b,
  input  wire logic [12:0] addr_b,
  input  wire logic [17:0] din_b,
  output logic      [17:0] dout_b,
  input  wire logic        read_pointer_clear,
  output logic             fifo_full_flag,
  output logic             fifo_nearly_full_flag,
  output logic             fifo_empty_flag,
  output logic             fifo_nearly_empty_flag,
  output logic             flash_rd,
  output logic      [15:0] flash_addr,
  input  wire logic [7:0]  flash_rdata,
  input  wire logic        flash_ack,
  output logic             loaded
);
  logic [31:0] ctrl;
  logic [14:0] af_level;
  logic [14:0] ae_level;
  logic        mem [0:eb_pkg::MEM_BITS-1];
  eb_pkg::eb_load_t ld_state;
  logic [10:0] ld_chunk;
  logic [1:0][17:0] raw;
  logic [1:0][17:0] out_q;
  logic [1:0][17:0] next_raw;
  logic [13:0] wptr;
  logic [13:0] rptr;
  logic [14:0] count;

  // Widths 1, 2, 4, 9; 18 only where the organisation allows it
  function automatic logic [4:0] width_of(input logic [2:0] code, input eb_pkg::eb_mode_t m);
    case (code)
      3'h0: width_of = 5'd1;
      3'h1: width_of = 5'd2;
      3'h2: width_of = 5'd4;
      3'h3: width_of = 5'd9;
      default: width_of = (m == eb_pkg::EB_PSEUDO || m == eb_pkg::EB_FIFO) ? 5'd18 : 5'd9;
    endcase
  endfunction

  function automatic logic [17:0] bit_base(input logic [12:0] a, input logic [4:0] w);
    bit_base = 18'(a) * 18'(w);
  endfunction

  // Mode and width decode
  wire eb_pkg::eb_mode_t mode = eb_pkg::eb_mode_t'(ctrl[eb_pkg::CTRL_MODE +: 3]);
  wire is_fifo = mode == eb_pkg::EB_FIFO;
  wire [4:0] w_a = width_of(ctrl[eb_pkg::CTRL_WA +: 3], mode);
  wire [4:0] w_b = (mode == eb_pkg::EB_SINGLE) ? w_a :
                   width_of(ctrl[eb_pkg::CTRL_WB +: 3], mode);
  wire [13:0] cap = (w_a >= 5'd9 || w_b >= 5'd9) ? eb_pkg::CAP_WIDE : eb_pkg::CAP_NARROW;

  // Port select with cascade decode
  wire sel_a = ce_a && cs_a == CS_MATCH_A && loaded;
  wire sel_b = ce_b && cs_b == CS_MATCH_B && loaded && mode != eb_pkg::EB_SINGLE;
  wire push  = sel_a && we_a && is_fifo && !fifo_full_flag;
  wire pop   = sel_b && is_fifo && !fifo_empty_flag;
  wire ram_w = mode == eb_pkg::EB_SINGLE || mode == eb_pkg::EB_TRUE_DUAL
               || mode == eb_pkg::EB_PSEUDO;
  wire [1:0] wr;
  wire [1:0] rd;
  assign wr[0] = (sel_a && we_a && ram_w) || push;
  assign wr[1] = sel_b && we_b && mode == eb_pkg::EB_TRUE_DUAL;
  assign rd[0] = sel_a && !is_fifo;
  assign rd[1] = is_fifo ? pop : sel_b;

  // Bit address of each port's word in the shared bit array
  wire [1:0][17:0] base;
  assign base[0] = is_fifo ? {4'h0, wptr} : bit_base(addr_a, w_a);
  assign base[1] = is_fifo ? {4'h0, rptr} : bit_base(addr_b, w_b);
  wire [1:0][4:0]  pw    = {w_b, w_a};
  wire [1:0][17:0] pdin  = {din_b, din_a};
  wire [1:0][1:0]  plane = {byte_lane_enable_b, byte_lane_enable_a};
  wire [1:0]       poreg = {ctrl[eb_pkg::CTRL_OREG_B], ctrl[eb_pkg::CTRL_OREG_A]};
  wire [1:0]       poce  = {output_register_gate_b, output_register_gate_a};
  wire [1:0]       pprst = {port_rst_b, port_rst_a};

  // Preload sequencer
  wire        ld_we   = (ld_state == eb_pkg::EB_LD_REQ && !INIT_FROM_FLASH)
                        || (ld_state == eb_pkg::EB_LD_WAIT && flash_ack);
  wire [7:0]  ld_data = INIT_FROM_FLASH ? flash_rdata : 8'h00;
  wire [13:0] ld_base = {ld_chunk, 3'b000};
  assign flash_rd   = INIT_FROM_FLASH && ld_state == eb_pkg::EB_LD_REQ;
  assign flash_addr = INIT_BASE + {5'h00, ld_chunk};
  assign loaded     = ld_state == eb_pkg::EB_LD_DONE;

  eb_pkg::eb_load_t next_ld_state;
  always_comb
  begin
    next_ld_state = ld_state;
    case (ld_state)
      eb_pkg::EB_LD_IDLE: next_ld_state = eb_pkg::EB_LD_REQ;
      eb_pkg::EB_LD_REQ:
        if (INIT_FROM_FLASH)
          next_ld_state = eb_pkg::EB_LD_WAIT;
        else if (ld_chunk == eb_pkg::LOAD_LAST)
          next_ld_state = eb_pkg::EB_LD_DONE;
      eb_pkg::EB_LD_WAIT:
        if (flash_ack)
          next_ld_state = (ld_chunk == eb_pkg::LOAD_LAST) ? eb_pkg::EB_LD_DONE
                                                          : eb_pkg::EB_LD_REQ;
      default: next_ld_state = eb_pkg::EB_LD_DONE;
    endcase
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      ld_state <= eb_pkg::EB_LD_IDLE;
      ld_chunk <= 11'h000;
    end
    else
    begin
      ld_state <= next_ld_state;
      if (ld_we)
        ld_chunk <= ld_chunk + 11'h001;
    end
  end

  // Storage array: inputs taken at the rising edge; port B wins a bit collision
  always_ff @(posedge clk)
  begin
    for (int p = 0; p < 2; p++)
      for (int i = 0; i < eb_pkg::DATA_W; i++)
        if (wr[p] && 5'(i) < pw[p] && plane[p][i >= 9]
            && base[p] + 18'(i) < {4'h0, cap})
          mem[14'(base[p] + 18'(i))] <= pdin[p][i];
    if (ld_we)
      for (int k = 0; k < eb_pkg::FLASH_W; k++)
        mem[ld_base + 14'(k)] <= ld_data[k];
  end

  always_comb
  begin
    next_raw = '0;
    for (int p = 0; p < 2; p++)
      for (int i = 0; i < eb_pkg::DATA_W; i++)
        if (5'(i) < pw[p] && base[p] + 18'(i) < {4'h0, cap})
          next_raw[p][i] = mem[14'(base[p] + 18'(i))];
  end

  // Read latch and optional output register per port
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      raw   <= '0;
      out_q <= '0;
    end
    else
      for (int p = 0; p < 2; p++)
      begin
        if (pprst[p])
        begin
          raw[p]   <= 18'h00000;
          out_q[p] <= 18'h00000;
        end
        else
        begin
          if (rd[p])
            raw[p] <= next_raw[p];
          if (poce[p])
            out_q[p] <= raw[p];
        end
      end
  end
  assign dout_a = poreg[0] ? out_q[0] : raw[0];
  assign dout_b = poreg[1] ? out_q[1] : raw[1];

  eb_fifo_ctl u_fifo (
    .clk          (clk),
    .rst          (rst),
    .push         (push),
    .pop          (pop),
    .clear        (read_pointer_clear && is_fifo),
    .wbits        (w_a),
    .rbits        (w_b),
    .cap          (cap),
    .af_level     (af_level),
    .ae_level     (ae_level),
    .wptr         (wptr),
    .rptr         (rptr),
    .count        (count),
    .full         (fifo_full_flag),
    .nearly_full  (fifo_nearly_full_flag),
    .empty        (fifo_empty_flag),
    .nearly_empty (fifo_nearly_empty_flag)
  );

  // APB slave: zero wait states, read data latched in the setup cycle
  wire hit_ctrl = paddr == eb_pkg::OFF_CTRL;
  wire hit_af   = paddr == eb_pkg::OFF_AF;
  wire hit_ae   = paddr == eb_pkg::OFF_AE;
  wire hit_st   = paddr == eb_pkg::OFF_STATUS;
  wire hit_ptr  = paddr == eb_pkg::OFF_PTRS;
  wire mapped   = hit_ctrl || hit_af || hit_ae || hit_st || hit_ptr;
  wire apb_wr   = psel && penable && pwrite && mapped;
  wire [31:0] status = {1'b0, count, 11'h000, fifo_nearly_empty_flag, fifo_empty_flag,
                        fifo_nearly_full_flag, fifo_full_flag, loaded};
  wire [31:0] rd_val = hit_ctrl ? ctrl
                     : hit_af   ? {17'h00000, af_level}
                     : hit_ae   ? {17'h00000, ae_level}
                     : hit_st   ? status
                     : hit_ptr  ? {2'b00, rptr, 2'b00, wptr}
                     : 32'h0000_0000;
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !mapped;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      ctrl     <= eb_pkg::CTRL_RESET;
      af_level <= eb_pkg::AF_RESET;
      ae_level <= eb_pkg::AE_RESET;
      prdata   <= 32'h0000_0000;
    end
    else
    begin
      if (apb_wr && hit_ctrl)
        ctrl <= pwdata & 32'h0000_3777;
      if (apb_wr && hit_af)
        af_level <= pwdata[14:0];
      if (apb_wr && hit_ae)
        ae_level <= pwdata[14:0];
      if (psel && !penable)
        prdata <= rd_val;
    end
  end

  rom_no_write_a: assert property (@(posedge clk) disable iff (rst)
    mode == eb_pkg::EB_ROM |-> wr == 2'b00)
    else $error("write in rom mode");
  load_sticks_a: assert property (@(posedge clk) disable iff (rst)
    loaded |=> loaded)
    else $error("loaded flag dropped");
  busy_ignore_a: assert property (@(posedge clk) disable iff (rst)
    !loaded |-> wr == 2'b00 && rd == 2'b00)
    else $error("port access during preload");
  zero_no_flash_a: assert property (@(posedge clk) disable iff (rst)
    !INIT_FROM_FLASH |-> !flash_rd)
    else $error("flash read for zero preload");
  first_addr_a: assert property (@(posedge clk) disable iff (rst)
    ld_state == eb_pkg::EB_LD_IDLE ##1 flash_rd |-> flash_addr == INIT_BASE)
    else $error("preload not started at its area base");
  out_reg_a: assert property (@(posedge clk) disable iff (rst)
    poreg[0] && output_register_gate_a && !port_rst_a && $stable(ctrl)
    |=> dout_a == $past(raw[0]))
    else $error("output register did not take array data");
  read_lat_a: assert property (@(posedge clk) disable iff (rst)
    rd[1] && !poreg[1] && !port_rst_b && $stable(ctrl) |=> dout_b == $past(next_raw[1]))
    else $error("read data late or wrong");
  idle_hold_a: assert property (@(posedge clk) disable iff (rst)
    !rd[0] && !port_rst_a && !poreg[0] ##1 !poreg[0] |-> $stable(dout_a))
    else $error("output changed without access");
  full_block_a: assert property (@(posedge clk) disable iff (rst)
    fifo_full_flag |-> !push)
    else $error("push while full");

  // Configuration, cascade, preload progress and FIFO pop while empty
  ctrl_write_a: assert property (@(posedge clk) disable iff (rst)
    apb_wr && hit_ctrl |=> ctrl == ($past(pwdata) & 32'h0000_3777))
    else $error("control word not taken from write");
  cascade_sel_a: assert property (@(posedge clk) disable iff (rst)
    cs_a != CS_MATCH_A |-> !wr[0] && !rd[0])
    else $error("port a active without chip select match");
  ld_step_a: assert property (@(posedge clk) disable iff (rst)
    ld_we |=> ld_chunk == $past(ld_chunk) + 11'h001)
    else $error("preload word counter did not advance");
  empty_no_pop_a: assert property (@(posedge clk) disable iff (rst)
    fifo_empty_flag |-> !pop)
    else $error("pop while empty");
endmodule

// ==== design/eb_fifo_ctl.sv ====
// Hardwired FIFO pointer and flag logic, counted in storage bits
module eb_fifo_ctl (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        push,
  input  wire logic        pop,
  input  wire logic        clear,
  input  wire logic [4:0]  wbits,
  input  wire logic [4:0]  rbits,
  input  wire logic [13:0] cap,
  input  wire logic [14:0] af_level,
  input  wire logic [14:0] ae_level,
  output logic      [13:0] wptr,
  output logic      [13:0] rptr,
  output logic      [14:0] count,
  output logic             full,
  output logic             nearly_full,
  output logic             empty,
  output logic             nearly_empty
);
  function automatic logic [13:0] step(input logic [13:0] p, input logic [4:0] w,
                                       input logic [13:0] c);
    logic [13:0] n;
    n = p + {9'h000, w};
    step = (n >= c) ? n - c : n;
  endfunction

  wire [14:0] add_w = push ? {10'h000, wbits} : 15'h0000;
  wire [14:0] sub_r = pop ? {10'h000, rbits} : 15'h0000;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      wptr  <= 14'h0000;
      rptr  <= 14'h0000;
      count <= 15'h0000;
    end
    else
    begin
      if (push)
        wptr <= step(wptr, wbits, cap);
      if (clear)
      begin
        rptr  <= 14'h0000;
        count <= {1'b0, wptr} + add_w;
      end
      else
      begin
        if (pop)
          rptr <= step(rptr, rbits, cap);
        count <= count + add_w - sub_r;
      end
    end
  end

  assign full         = (count + {10'h000, wbits}) > {1'b0, cap};
  assign empty        = count < {10'h000, rbits};
  assign nearly_full  = count >= af_level;
  assign nearly_empty = count <= ae_level;

  clear_ptr_a: assert property (@(posedge clk) disable iff (rst)
    clear |=> rptr == 14'h0000)
    else $error("read pointer not cleared");
  count_cap_a: assert property (@(posedge clk) disable iff (rst)
    count <= {1'b0, cap} || $changed(cap))
    else $error("fifo count above capacity");
  push_moves_a: assert property (@(posedge clk) disable iff (rst)
    push && wbits != 5'h00 |=> wptr != $past(wptr))
    else $error("write pointer did not move on push");
endmodule

// ==== design/eb_pkg.sv ====
// Constants, types and field layout shared by the embedded block memory design
// Summary of operation
// - Block works as RAM, ROM or FIFO
// - FIFO pointers and flags are built in
// - Single and true dual: widths 1, 2, 4, 9
// - Pseudo dual and FIFO add 18-bit width
// - Each port picks its own width
// - Bits packed word 0 LSB upward, all ports
// - Optional preload from user flash store
// - All-zero preload reads no flash bits
// - Equal patterns share one flash area
// - Cascading uses chip select decode per block
// - Inputs registered, output register optional
// - Rising edge; controls all active high
// - FIFO gives full, empty and near flags
package eb_pkg;
  localparam int          DATA_W      = 18;
  localparam int          ADDR_W      = 13;
  localparam int          PTR_W       = 14;
  localparam int          CNT_W       = 15;
  localparam int          MEM_BITS    = 9216;
  localparam int          FLASH_W     = 8;
  localparam logic [13:0] CAP_NARROW  = 14'h2000;
  localparam logic [13:0] CAP_WIDE    = 14'h2400;
  localparam logic [10:0] LOAD_LAST   = 11'h47f;
  localparam logic [11:0] OFF_CTRL    = 12'h000;
  localparam logic [11:0] OFF_AF      = 12'h004;
  localparam logic [11:0] OFF_AE      = 12'h008;
  localparam logic [11:0] OFF_STATUS  = 12'h00c;
  localparam logic [11:0] OFF_PTRS    = 12'h010;
  localparam int          CTRL_MODE   = 0;
  localparam int          CTRL_WA     = 4;
  localparam int          CTRL_WB     = 8;
  localparam int          CTRL_OREG_A = 12;
  localparam int          CTRL_OREG_B = 13;
  localparam logic [31:0] CTRL_RESET  = 32'h0000_0330;
  localparam logic [14:0] AF_RESET    = 15'h1f00;
  localparam logic [14:0] AE_RESET    = 15'h0100;

  typedef enum logic [2:0] {
    EB_SINGLE    = 3'h0,
    EB_TRUE_DUAL = 3'h1,
    EB_PSEUDO    = 3'h2,
    EB_ROM       = 3'h3,
    EB_FIFO      = 3'h4
  } eb_mode_t;

  typedef enum logic [1:0] {
    EB_LD_IDLE = 2'b00,
    EB_LD_REQ  = 2'b01,
    EB_LD_WAIT = 2'b11,
    EB_LD_DONE = 2'b10
  } eb_load_t;
endpackage

// ==== sim/eb_embedded_block_ram_tb.sv ====
// Self-checking bench for the embedded block memory
module eb_embedded_block_ram_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic          clk;
  logic          rst;
  logic          psel;
  logic          penable;
  logic          pwrite;
  logic [11:0]   paddr;
  logic [31:0]   pwdata;
  logic [31:0]   prdata;
  logic          pready;
  logic          pslverr;
  logic          ce [2];
  logic          gate [2];
  logic          prst [2];
  logic [1:0]    be [2];
  logic          wen [2];
  logic [2:0]    cs [2];
  logic [12:0]   ad [2];
  logic [17:0]   di [2];
  logic [17:0]   dq [2];
  logic          rpc;
  logic [3:0]    fl;
  logic          flash_rd;
  logic          flash_ack;
  logic          loaded;
  logic [15:0]   flash_addr;
  logic [7:0]    flash_rdata;
  logic [9215:0] sh;
  logic [31:0]   rv;
  logic          ev;
  logic [17:0]   pv;
  int            err_count;
  int            n_checks;
  int            cyc;

  eb_embedded_block_ram #(.INIT_FROM_FLASH(1'b1), .INIT_BASE(16'h0100)) dut (
    .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ce_a(ce[0]), .output_register_gate_a(gate[0]), .port_rst_a(prst[0]),
    .byte_lane_enable_a(be[0]), .we_a(wen[0]), .cs_a(cs[0]), .addr_a(ad[0]),
    .din_a(di[0]), .dout_a(dq[0]), .ce_b(ce[1]), .output_register_gate_b(gate[1]),
    .port_rst_b(prst[1]), .byte_lane_enable_b(be[1]), .we_b(wen[1]), .cs_b(cs[1]),
    .addr_b(ad[1]), .din_b(di[1]), .dout_b(dq[1]), .read_pointer_clear(rpc),
    .fifo_full_flag(fl[3]), .fifo_nearly_full_flag(fl[2]), .fifo_empty_flag(fl[1]),
    .fifo_nearly_empty_flag(fl[0]), .flash_rd(flash_rd), .flash_addr(flash_addr),
    .flash_rdata(flash_rdata), .flash_ack(flash_ack), .loaded(loaded));

  eb_flash_model flash (.clk(clk), .rst(rst), .flash_rd(flash_rd),
    .flash_addr(flash_addr), .flash_rdata(flash_rdata), .flash_ack(flash_ack));

  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic end_of_test();
    $display("checks %0d, mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      err_count++;
      end_of_test();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int i;
    @(posedge clk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    i = 0;
    do
    begin
      @(posedge clk);
      i++;
    end
    while (pready !== 1'b1);
    rv = prdata;
    ev = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic port(input int p, input logic w, input int a, input logic [17:0] d);
    @(posedge clk);
    ce[p]  <= 1'b1;
    wen[p] <= w;
    ad[p]  <= 13'(a);
    di[p]  <= d;
    @(posedge clk);
    ce[p]  <= 1'b0;
    wen[p] <= 1'b0;
    @(negedge clk);
    pv = dq[p];
  endtask

  task automatic set_mode(input int m, input int ca, input int cb, input int oa);
    apb(1'b1, eb_pkg::OFF_CTRL, 32'((oa << 12) | (cb << 8) | (ca << 4) | m));
  endtask

  function automatic int wd(input int c);
    return (c == 3 || c > 3) ? 9 : 1 << c;
  endfunction

  function automatic logic [31:0] xr(input int a, input int w, input int cap);
    xr = '0;
    for (int i = 0; i < w; i++)
      if (a * w + i < cap)
        xr[i] = sh[a * w + i];
  endfunction

  function automatic void sh_wr(input int a, input int w, input logic [17:0] d, input int cap);
    for (int i = 0; i < w; i++)
      if (a * w + i < cap)
        sh[a * w + i] = d[i];
  endfunction

  initial
  begin
    int i, a, b, w, w2, cap;
    logic [17:0] d;
    logic [17:0] q [$];
    logic [7:0] bt;
    {psel, penable, pwrite, paddr, pwdata, rpc, err_count, n_checks, cyc} = '0;
    for (i = 0; i < 2; i++)
    begin
      {ce[i], gate[i], prst[i], wen[i], ad[i], di[i]} = '0;
      be[i] = 2'b11;
      cs[i] = 3'h7;
    end
    void'($urandom(32'h8d18));
    rst = 1'b1;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    for (i = 0; i < 9216; i++)
    begin
      bt = 8'(i / 8 + 256) ^ 8'h3c;
      sh[i] = bt[i % 8];
    end
    // Writes during preload must be ignored
    port(0, 1'b1, 0, 18'h1ff);
    apb(1'b0, eb_pkg::OFF_CTRL, '0);
    chk(rv, eb_pkg::CTRL_RESET);
    apb(1'b0, eb_pkg::OFF_AF, '0);
    chk(rv, 32'(eb_pkg::AF_RESET));
    apb(1'b0, eb_pkg::OFF_AE, '0);
    chk(rv, 32'(eb_pkg::AE_RESET));
    apb(1'b0, 12'h0f0, '0);
    chk({rv[30:0], ev}, 32'h1);
    i = 0;
    while (loaded !== 1'b1 && i < 9000)
    begin
      @(posedge clk);
      i++;
    end
    apb(1'b0, eb_pkg::OFF_STATUS, '0);
    chk(rv[0], 1'b1);
    for (i = 0; i < 6; i++)
    begin
      a = (i == 0) ? 0 : (i == 1) ? 1023 : $urandom_range(1023);
      port(0, 1'b0, a, '0);
      chk(pv, xr(a, 9, 9216));
    end
    for (int c = 0; c < 5; c++)
    begin
      set_mode(eb_pkg::EB_TRUE_DUAL, c, (c + 1) % 5, 0);
      w = wd(c);
      w2 = wd((c + 1) % 5);
      cap = (w == 9 || w2 == 9) ? 9216 : 8192;
      a = $urandom_range(8191 / w);
      d = 18'($urandom);
      port(0, 1'b1, a, d);
      sh_wr(a, w, d, cap);
      port(0, 1'b0, a, '0);
      chk(pv, xr(a, w, cap));
      b = a * w / w2;
      port(1, 1'b0, b, '0);
      chk(pv, xr(b, w2, cap));
      d = 18'($urandom);
      port(1, 1'b1, b, d);
      sh_wr(b, w2, d, cap);
      port(0, 1'b0, a, '0);
      chk(pv, xr(a, w, cap));
    end
    set_mode(eb_pkg::EB_PSEUDO, 4, 0, 0);
    a = $urandom_range(454);
    d = 18'($urandom);
    port(0, 1'b1, a, d);
    sh_wr(a, 18, d, 9216);
    port(1, 1'b1, a * 18 + 17, ~d);
    for (i = 0; i < 18; i += 17)
    begin
      port(1, 1'b0, a * 18 + i, '0);
      chk(pv, xr(a * 18 + i, 1, 9216));
    end
    for (i = 0; i < 3; i++)
    begin
      set_mode(i == 2 ? eb_pkg::EB_ROM : eb_pkg::EB_SINGLE, 3, 3, 0);
      cs[0] <= (i == 0) ? 3'h3 : 3'h7;
      be[0] <= (i == 1) ? 2'b00 : 2'b11;
      port(0, 1'b1, 5, ~xr(5, 9, 9216));
      @(posedge clk);
      cs[0] <= 3'h7;
      be[0] <= 2'b11;
      port(0, 1'b0, 5, '0);
      chk(pv, xr(5, 9, 9216));
    end
    set_mode(eb_pkg::EB_SINGLE, 3, 3, 1);
    port(0, 1'b1, 7, 18'h1a5);
    port(0, 1'b0, 7, '0);
    // Output register never gated since reset, so it still holds zero
    chk(pv, 32'h0);
    @(posedge clk);
    gate[0] <= 1'b1;
    @(posedge clk);
    gate[0] <= 1'b0;
    @(negedge clk);
    chk(dq[0], 32'h1a5);
    @(posedge clk);
    prst[0] <= 1'b1;
    @(posedge clk);
    prst[0] <= 1'b0;
    @(negedge clk);
    chk(dq[0], 32'h0);
    apb(1'b1, eb_pkg::OFF_AF, 32'd27);
    apb(1'b1, eb_pkg::OFF_AE, 32'd9);
    set_mode(eb_pkg::EB_FIFO, 3, 3, 0);
    @(negedge clk);
    chk(fl, 4'b0011);
    for (i = 0; i < 3; i++)
    begin
      q.push_back(18'($urandom_range(511)));
      port(0, 1'b1, 0, q[i]);
    end
    chk(fl, 4'b0100);
    port(1, 1'b0, 0, '0);
    chk({fl, 10'h0, pv}, {4'b0000, 10'h0, q[0]});
    @(posedge clk);
    rpc <= 1'b1;
    @(posedge clk);
    rpc <= 1'b0;
    @(negedge clk);
    apb(1'b0, eb_pkg::OFF_PTRS, '0);
    chk({rv[29:16], fl}, {14'h0, 4'b0100});
    port(1, 1'b0, 0, '0);
    chk(pv, q[0]);
    for (int p = 0; p < 2; p++)
    begin
      repeat (1023 + p * 3)
      begin
        @(posedge clk);
        ce[p]  <= 1'b1;
        wen[p] <= (p == 0);
        di[p]  <= 18'($urandom_range(511));
      end
      @(posedge clk);
      ce[p]  <= 1'b0;
      wen[p] <= 1'b0;
      apb(1'b0, eb_pkg::OFF_STATUS, '0);
      chk({rv[30:16], fl}, p ? {15'd0, 4'b0011} : {15'd9216, 4'b1100});
    end
    end_of_test();
  end
endmodule

// ==== sim/eb_flash_model.sv ====
// Behavioural user flash store answering preload word requests
module eb_flash_model (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        flash_rd,
  input  wire logic [15:0] flash_addr,
  output logic      [7:0]  flash_rdata,
  output logic             flash_ack
);
  timeunit 1ns;
  timeprecision 1ns;
  logic        pend;
  logic [15:0] wa;
  int          gap;
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      pend        <= 1'b0;
      flash_ack   <= 1'b0;
      flash_rdata <= 8'h00;
      wa          <= 16'h0000;
      gap         <= 0;
    end
    else
    begin
      flash_ack   <= 1'b0;
      // Data is only meaningful with the ack
      flash_rdata <= ~flash_rdata;
      if (pend && gap == 0)
      begin
        flash_ack   <= 1'b1;
        flash_rdata <= wa[7:0] ^ 8'h3c;
        pend        <= 1'b0;
      end
      else if (pend)
        gap <= gap - 1;
      else if (flash_rd)
      begin
        pend <= 1'b1;
        wa   <= flash_addr;
        gap  <= $urandom_range(2);
      end
    end
  end
endmodule
